// file: design/tmc_pkg.sv
// ==========================================================================
// Shared constants and types for the transceiver mode control block
package tmc_pkg;

    // ======================================================================
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFS      = 8'h00;
    localparam logic [7:0] PDGAIN_OFFS    = 8'h04;
    localparam logic [7:0] STATUS_OFFS    = 8'h08;

    // ======================================================================
    // Field positions
    localparam int         CTRL_RXCAL_BIT = 0;
    localparam int         CTRL_TXCAL_BIT = 1;
    localparam int         STAT_MODE_LSB  = 0;
    localparam int         STAT_EN_LSB    = 4;

    // ======================================================================
    // Values after reset
    localparam logic [1:0] CTRL_RESET     = 2'h0;
    localparam logic [1:0] PDGAIN_RESET   = 2'h0;

    // ======================================================================
    // AXI4-Lite responses
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ======================================================================
    // Operating modes
    typedef enum logic [2:0] {
        MODE_SHUTDOWN,
        MODE_STANDBY,
        MODE_RX,
        MODE_TX,
        MODE_RXCAL,
        MODE_TXCAL
    } tmc_mode_t;

    // Circuit block enables
    typedef struct packed {
        logic synthEn;      // PLL, VCO, LO generators, auto-tuner
        logic rxPathEn;
        logic lnaEn;
        logic txPathEn;
        logic upconvEn;
        logic paDrvEn;      // PA driver and external PA
        logic calToneEn;
        logic rfPhaseEn;
        logic txFilterEn;
        logic rfLoopbackEn; // Tx RF routed into Rx inputs
        logic amDetEn;
        logic rxIqBufEn;
        logic rxMuxDet;     // Rx multiplexers carry detector signal
    } tmc_blocks_t;

endpackage

// file: design/tmc_mode_ctrl.sv
// Overview of operation
// - Shutdown: pins low, all off except registers
// - Standby: only synthesizer, PLL, VCO, LO on
// - Power on, path low: receive path on
// - Power on, path high: transmit path on
// - Tx calibration: transmit on except PA driver
// - Tx calibration: detector, I/Q buffers, muxes on
// - Tx calibration: detector output on Rx I/Q
// - Detector power tracks leakage one-to-one in dB
// - Rx calibration: Tx RF looped back, LNA off
// - Rx mode plus bit D0 selects Rx calibration
// - Tx mode plus bit D1 selects Tx calibration
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module tmc_mode_ctrl #(
    parameter int IQ_W = 10
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // Mode pins
    input  wire logic              powerOnCtlN,
    input  wire logic              pathSelect,
    // Baseband sample paths
    input  wire logic [IQ_W-1:0]   rxDataI,
    input  wire logic [IQ_W-1:0]   rxDataQ,
    input  wire logic [IQ_W-1:0]   detI,
    input  wire logic [IQ_W-1:0]   detQ,
    output logic      [IQ_W-1:0]   rxOutI,
    output logic      [IQ_W-1:0]   rxOutQ,
    // Block enables
    output tmc_pkg::tmc_blocks_t   blockEn,
    output tmc_pkg::tmc_mode_t     mode,
    output logic      [1:0]        pdGain,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ======================================================================
    // State
    typedef struct packed {
        logic                 awHave;
        logic [7:0]           awAddr;
        logic                 wHave;
        logic [31:0]          wData;
        logic [3:0]           wStrb;
        logic                 awReady;
        logic                 wReady;
        logic                 bValid;
        logic [1:0]           bResp;
        logic                 arReady;
        logic                 rValid;
        logic [31:0]          rData;
        logic [1:0]           rResp;
        logic [1:0]           calSel;
        logic [1:0]           pdGain;
        tmc_pkg::tmc_mode_t   mode;
        tmc_pkg::tmc_blocks_t blocks;
        logic [IQ_W-1:0]      outI;
        logic [IQ_W-1:0]      outQ;
    } tmc_state_t;

    tmc_state_t st_reg;
    tmc_state_t st_next;
    tmc_pkg::tmc_mode_t   modeDec;
    tmc_pkg::tmc_blocks_t blkDec;

    // ======================================================================
    // Mode decode from pins and calibration bits
    always_comb begin
        unique case ({powerOnCtlN, pathSelect})
            2'b00: begin
                // Powered down: calibration selects ignored
                modeDec = tmc_pkg::MODE_SHUTDOWN;
            end
            2'b01: begin
                modeDec = tmc_pkg::MODE_STANDBY;
            end
            2'b10: begin
                if (st_reg.calSel[tmc_pkg::CTRL_RXCAL_BIT]) begin
                    modeDec = tmc_pkg::MODE_RXCAL;
                end else begin
                    modeDec = tmc_pkg::MODE_RX;
                end
            end
            2'b11: begin
                if (st_reg.calSel[tmc_pkg::CTRL_TXCAL_BIT]) begin
                    modeDec = tmc_pkg::MODE_TXCAL;
                end else begin
                    modeDec = tmc_pkg::MODE_TX;
                end
            end
        endcase
    end

    // ======================================================================
    // Circuit block states per mode
    always_comb begin
        blkDec = '0;
        unique case (modeDec)
            tmc_pkg::MODE_SHUTDOWN: begin
                // Only the bus and registers stay alive
                blkDec = '0;
            end
            tmc_pkg::MODE_STANDBY: begin
                blkDec.synthEn = 1'b1;
            end
            tmc_pkg::MODE_RX: begin
                blkDec.synthEn  = 1'b1;
                blkDec.rxPathEn = 1'b1;
                blkDec.lnaEn    = 1'b1;
            end
            tmc_pkg::MODE_TX: begin
                blkDec.synthEn  = 1'b1;
                blkDec.txPathEn = 1'b1;
                blkDec.upconvEn = 1'b1;
                blkDec.paDrvEn  = 1'b1;
            end
            tmc_pkg::MODE_RXCAL: begin
                // Upconverters feed the Rx inputs; LNA stays off
                blkDec.synthEn      = 1'b1;
                blkDec.rxPathEn     = 1'b1;
                blkDec.upconvEn     = 1'b1;
                blkDec.rfLoopbackEn = 1'b1;
                blkDec.calToneEn    = 1'b1;
                blkDec.rfPhaseEn    = 1'b1;
                blkDec.txFilterEn   = 1'b1;
            end
            tmc_pkg::MODE_TXCAL: begin
                // PA driver and external PA stay off
                blkDec.synthEn   = 1'b1;
                blkDec.txPathEn  = 1'b1;
                blkDec.upconvEn  = 1'b1;
                blkDec.amDetEn   = 1'b1;
                blkDec.rxIqBufEn = 1'b1;
                blkDec.rxMuxDet  = 1'b1;
            end
        endcase
    end

    // ======================================================================
    // Next state: bus slave, registers, registered outputs
    always_comb begin
        logic       doWrite;
        logic       mapped;
        logic [7:0] rAddr;

        // Locals start clear; every field holds unless changed
        doWrite = 1'b0;
        mapped  = 1'b0;
        rAddr   = 8'h00;
        st_next = st_reg;

        // Mode and block states follow the decode every cycle
        st_next.mode   = modeDec;
        st_next.blocks = blkDec;

        // Rx outputs carry detector during Tx calibration, unscaled
        if (blkDec.rxMuxDet) begin
            st_next.outI = detI;
            st_next.outQ = detQ;
        end else begin
            st_next.outI = rxDataI;
            st_next.outQ = rxDataQ;
        end

        // Write address and data taken in either order
        if (s_axi_awvalid && st_reg.awReady) begin
            st_next.awHave = 1'b1;
            st_next.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_reg.wReady) begin
            st_next.wHave = 1'b1;
            st_next.wData = s_axi_wdata;
            st_next.wStrb = s_axi_wstrb;
        end

        // Response completes
        if (st_reg.bValid && s_axi_bready) begin
            st_next.bValid = 1'b0;
        end

        // Registers accept writes in every mode, shutdown included
        if (st_next.awHave && st_next.wHave && !st_next.bValid) begin
            doWrite        = 1'b1;
            st_next.awHave = 1'b0;
            st_next.wHave  = 1'b0;
            st_next.bValid = 1'b1;
            st_next.bResp  = tmc_pkg::RESP_OKAY;
            // Register map decode for the held address
            unique case (st_next.awAddr)
                tmc_pkg::CTRL_OFFS: begin
                    if (st_next.wStrb[0]) begin
                        st_next.calSel = st_next.wData[1:0];
                    end
                end
                tmc_pkg::PDGAIN_OFFS: begin
                    if (st_next.wStrb[0]) begin
                        st_next.pdGain = st_next.wData[1:0];
                    end
                end
                tmc_pkg::STATUS_OFFS: begin
                    // Read-only: answered OKAY, nothing stored
                    doWrite = 1'b1;
                end
                default: begin
                    st_next.bResp = tmc_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Readies drop while a write is held or answered
        st_next.awReady = !st_next.awHave && !st_next.bValid && !doWrite;
        st_next.wReady  = !st_next.wHave && !st_next.bValid && !doWrite;

        // Read channel
        if (st_reg.rValid && s_axi_rready) begin
            st_next.rValid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.arReady) begin
            rAddr          = s_axi_araddr;
            st_next.rValid = 1'b1;
            st_next.rData  = 32'h0000_0000;
            st_next.rResp  = tmc_pkg::RESP_OKAY;
            mapped         = 1'b1;
            // Upper bits read as zero
            unique case (rAddr)
                tmc_pkg::CTRL_OFFS: begin
                    st_next.rData[1:0] = st_reg.calSel;
                end
                tmc_pkg::PDGAIN_OFFS: begin
                    st_next.rData[1:0] = st_reg.pdGain;
                end
                tmc_pkg::STATUS_OFFS: begin
                    st_next.rData[tmc_pkg::STAT_MODE_LSB +: 3] = st_reg.mode;
                    st_next.rData[tmc_pkg::STAT_EN_LSB +: 13]  = st_reg.blocks;
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
            if (!mapped) begin
                st_next.rResp = tmc_pkg::RESP_SLVERR;
            end
        end
        st_next.arReady = !st_next.rValid;
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg         <= '0;
            st_reg.mode    <= tmc_pkg::MODE_SHUTDOWN;
            st_reg.calSel  <= tmc_pkg::CTRL_RESET;
            st_reg.pdGain  <= tmc_pkg::PDGAIN_RESET;
            // Channels come out of reset ready
            st_reg.awReady <= 1'b1;
            st_reg.wReady  <= 1'b1;
            st_reg.arReady <= 1'b1;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ======================================================================
    // Outputs straight from state
    assign rxOutI        = st_reg.outI;
    assign rxOutQ        = st_reg.outQ;
    assign blockEn       = st_reg.blocks;
    assign mode          = st_reg.mode;
    assign pdGain        = st_reg.pdGain;

    // Write channel outputs
    assign s_axi_awready = st_reg.awReady;
    assign s_axi_wready  = st_reg.wReady;
    assign s_axi_bresp   = st_reg.bResp;
    assign s_axi_bvalid  = st_reg.bValid;

    // Read channel outputs
    assign s_axi_arready = st_reg.arReady;
    assign s_axi_rdata   = st_reg.rData;
    assign s_axi_rresp   = st_reg.rResp;
    assign s_axi_rvalid  = st_reg.rValid;

endmodule

// file: test/tmc_mode_ctrl_assertions.sv
`timescale 1ns/100ps
// ==========================================
// Mode decode and block enable checks
module tmc_mode_ctrl_assertions #(
    parameter int IQ_W = 10
) (
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 ce,
    input wire logic                 powerOnCtlN,
    input wire logic                 pathSelect,
    input wire logic [IQ_W-1:0]      rxDataI,
    input wire logic [IQ_W-1:0]      rxDataQ,
    input wire logic [IQ_W-1:0]      detI,
    input wire logic [IQ_W-1:0]      detQ,
    input wire logic [IQ_W-1:0]      rxOutI,
    input wire logic [IQ_W-1:0]      rxOutQ,
    input wire tmc_pkg::tmc_blocks_t blockEn,
    input wire tmc_pkg::tmc_mode_t   mode
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Pins decide the mode one cycle later
    off_decode_a: assert property (ce && !powerOnCtlN |=>
        mode == ($past(pathSelect) ? tmc_pkg::MODE_STANDBY : tmc_pkg::MODE_SHUTDOWN)) else $error("off decode");
    rx_decode_a: assert property (ce && powerOnCtlN && !pathSelect |=>
        mode inside {tmc_pkg::MODE_RX, tmc_pkg::MODE_RXCAL}) else $error("rx decode");
    tx_decode_a: assert property (ce && powerOnCtlN && pathSelect |=>
        mode inside {tmc_pkg::MODE_TX, tmc_pkg::MODE_TXCAL}) else $error("tx decode");
    // Enables follow the mode
    off_blocks_a: assert property (mode == tmc_pkg::MODE_SHUTDOWN |-> blockEn == '0)
        else $error("shutdown enables");
    standby_blocks_a: assert property (mode == tmc_pkg::MODE_STANDBY |-> blockEn == 13'h1000)
        else $error("standby enables");
    rx_blocks_a: assert property (mode == tmc_pkg::MODE_RX |-> blockEn.rxPathEn && blockEn.lnaEn
        && blockEn.synthEn && !blockEn.txPathEn && !blockEn.paDrvEn) else $error("rx enables");
    tx_blocks_a: assert property (mode == tmc_pkg::MODE_TX |-> blockEn.txPathEn && blockEn.paDrvEn
        && !blockEn.rxPathEn) else $error("tx enables");
    txcal_blocks_a: assert property (mode == tmc_pkg::MODE_TXCAL |-> blockEn.txPathEn
        && !blockEn.paDrvEn && blockEn.amDetEn && blockEn.rxIqBufEn && blockEn.rxMuxDet) else $error("txcal enables");
    rxcal_blocks_a: assert property (mode == tmc_pkg::MODE_RXCAL |-> !blockEn.lnaEn
        && blockEn.rfLoopbackEn && blockEn.calToneEn && blockEn.rfPhaseEn && blockEn.txFilterEn
        && blockEn.synthEn) else $error("rxcal enables");
    // Receive outputs carry detector or received samples
    det_route_a: assert property (mode == tmc_pkg::MODE_TXCAL && $past(ce) |->
        rxOutI == $past(detI) && rxOutQ == $past(detQ)) else $error("detector route");
    rx_route_a: assert property (mode == tmc_pkg::MODE_RX && $past(ce) |->
        rxOutI == $past(rxDataI) && rxOutQ == $past(rxDataQ)) else $error("rx route");
    cover property (mode == tmc_pkg::MODE_RXCAL);
    cover property (mode == tmc_pkg::MODE_TXCAL);
    cover property (mode == tmc_pkg::MODE_STANDBY);
endmodule
bind tmc_mode_ctrl tmc_mode_ctrl_assertions #(.IQ_W(IQ_W)) u_chk (.clk, .rst_b, .ce, .powerOnCtlN,
    .pathSelect, .rxDataI, .rxDataQ, .detI, .detQ, .rxOutI, .rxOutQ, .blockEn, .mode);

// file: test/tmc_baseband_model.sv
`timescale 1ns/100ps
// ==========================================
// Baseband controller: mode pins and calibration tones
module tmc_baseband_model #(
    parameter int IQ_W = 10
) (
    input  wire logic            clk,
    output logic                 powerOnCtlN,
    output logic                 pathSelect,
    output logic      [IQ_W-1:0] rxDataI,
    output logic      [IQ_W-1:0] rxDataQ,
    output logic      [IQ_W-1:0] detI,
    output logic      [IQ_W-1:0] detQ
);
    logic [IQ_W-1:0] phaseReg;
    // Pins start in shutdown
    initial begin
        powerOnCtlN = 1'h0;
        pathSelect  = 1'h0;
        phaseReg    = '0;
    end
    // Tone phase steps every cycle so a stale sample never matches
    always @(posedge clk) begin
        phaseReg <= phaseReg + 1'h1;
    end
    // Quadrature tones on the sample lines
    assign detI    = phaseReg;
    assign detQ    = ~phaseReg;
    assign rxDataI = {phaseReg[IQ_W-2:0], phaseReg[IQ_W-1]};
    assign rxDataQ = {phaseReg[0], phaseReg[IQ_W-1:1]};
    // Pins change just after an edge
    task automatic set_pins(input logic on, input logic tx);
        powerOnCtlN <= on;
        pathSelect  <= tx;
    endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/100ps
// ==========================================
// Self-checking bench for the mode control block
module testbench;
    localparam int IQ_W = 10;
    logic                 clk, rst_b, ce, powerOnCtlN, pathSelect;
    logic      [IQ_W-1:0] rxDataI, rxDataQ, detI, detQ, rxOutI, rxOutQ;
    tmc_pkg::tmc_blocks_t blockEn;
    tmc_pkg::tmc_mode_t   mode;
    logic      [1:0]      pdGain, s_axi_bresp, s_axi_rresp, resp;
    logic      [7:0]      s_axi_awaddr, s_axi_araddr;
    logic      [31:0]     s_axi_wdata, s_axi_rdata, rv;
    logic      [3:0]      s_axi_wstrb;
    logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic      [2:0]      expMode;
    int                   fail_count, n_compared;

    tmc_mode_ctrl #(.IQ_W(IQ_W)) dut (.clk, .rst_b, .ce, .powerOnCtlN, .pathSelect, .rxDataI, .rxDataQ,
        .detI, .detQ, .rxOutI, .rxOutQ, .blockEn, .mode, .pdGain, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    tmc_baseband_model #(.IQ_W(IQ_W)) bb (.clk, .powerOnCtlN, .pathSelect, .rxDataI, .rxDataQ, .detI, .detQ);

    // Clock at 25 MHz
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register write: address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    // Register read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // Counts and verdict
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end

    // ==========================================
    // Test sequence
    initial begin
        {rst_b, ce, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        fail_count = 0;
        n_compared = 0;
        ce = 1'h1;
        repeat (20) @(posedge clk);
        rst_b <= 1'h1;
        rd(tmc_pkg::CTRL_OFFS, rv, resp);
        chk(rv, {30'h0, tmc_pkg::CTRL_RESET});
        wr(tmc_pkg::CTRL_OFFS, 32'h0, resp);
        chk(resp, tmc_pkg::RESP_OKAY);
        $display("test reset done");
        // Every select value against every pin pair; writes land in shutdown
        for (int c = 0; c < 4; c++) begin
            wr(tmc_pkg::CTRL_OFFS, c, resp);
            for (int p = 0; p < 4; p++) begin
                bb.set_pins(p[1], p[0]);
                repeat (3) @(posedge clk);
                expMode = p == 0 ? tmc_pkg::MODE_SHUTDOWN : p == 1 ? tmc_pkg::MODE_STANDBY : p == 2 ?
                    (c[0] ? tmc_pkg::MODE_RXCAL : tmc_pkg::MODE_RX) : (c[1] ? tmc_pkg::MODE_TXCAL : tmc_pkg::MODE_TX);
                chk(mode, expMode);
                chk(blockEn.paDrvEn, p == 3 && !c[1]);
                chk(blockEn.lnaEn, p == 2 && !c[0]);
                chk(blockEn.synthEn, p != 0);
                rd(tmc_pkg::STATUS_OFFS, rv, resp);
                chk(rv[2:0], expMode);
                chk(rv[16], p != 0);
            end
            bb.set_pins(1'h0, 1'h0);
        end
        $display("test mode table done");
        wr(tmc_pkg::PDGAIN_OFFS, 32'h2, resp);
        repeat (2) @(posedge clk);
        chk(pdGain, 2'h2);
        rd(tmc_pkg::PDGAIN_OFFS, rv, resp);
        chk(rv, 32'h2);
        $display("test detector gain done");
        wr(8'h0c, 32'h1, resp);
        chk(resp, tmc_pkg::RESP_SLVERR);
        rd(8'h0c, rv, resp);
        chk(resp, tmc_pkg::RESP_SLVERR);
        $display("test unmapped done");
        // Clock enable low holds the decoded mode
        bb.set_pins(1'h1, 1'h1);
        repeat (3) @(posedge clk);
        ce <= 1'h0;
        bb.set_pins(1'h0, 1'h1);
        repeat (3) @(posedge clk);
        chk(mode, tmc_pkg::MODE_TXCAL);
        ce <= 1'h1;
        repeat (3) @(posedge clk);
        chk(mode, tmc_pkg::MODE_STANDBY);
        $display("test clock enable done");
        // Mid-run reset clears the calibration selects
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        chk(mode, tmc_pkg::MODE_SHUTDOWN);
        rst_b <= 1'h1;
        rd(tmc_pkg::CTRL_OFFS, rv, resp);
        chk(rv, {30'h0, tmc_pkg::CTRL_RESET});
        $display("test mid-run reset done");
        final_report();
    end
endmodule
